// ### rtl/mapper_pkg.sv
// constants for the processor address mapper block
package mapper_pkg;

  // ------------------------------------------------------------------
  // programmable mapper slots
  // ------------------------------------------------------------------
  localparam int NPROG = 6;
  localparam int NCODE = 2;
  localparam int SLOT_CODE_ONE = 0;
  localparam int SLOT_CODE_TWO = 1;
  localparam int SLOT_DATA_ONE = 2;
  localparam int SLOT_DATA_TWO = 3;
  localparam int SLOT_DATA_FOUR = 4;
  localparam int SLOT_DATA_FIVE = 5;

  // ------------------------------------------------------------------
  // register offsets within the config zone, A15:12 taken as Fh
  // ------------------------------------------------------------------
  localparam logic [15:0] LOW_OFS [NPROG] =
    '{16'hff02, 16'hff08, 16'hff0f, 16'hff14, 16'hff80, 16'hff85};
  localparam logic [15:0] MID_OFS [NPROG] =
    '{16'hff03, 16'hff09, 16'hff10, 16'hff15, 16'hff81, 16'hff86};
  localparam logic [15:0] HIGH_OFS [NPROG] =
    '{16'hff04, 16'hff0a, 16'hff11, 16'hff16, 16'hff82, 16'hff87};
  localparam logic [15:0] SRC_OFS [NPROG] =
    '{16'hff05, 16'hff0b, 16'hff12, 16'hff17, 16'hff83, 16'hff88};
  localparam logic [15:0] CTL_OFS [NPROG] =
    '{16'hff06, 16'hff0c, 16'hff13, 16'hff18, 16'hff84, 16'hff89};
  localparam logic [15:0] ALT_OFS [NCODE] = '{16'hff07, 16'hff0d};
  localparam logic [15:0] ROM_OPERAND_OFS = 16'hff00;
  localparam logic [15:0] ROM_OPCODE_OFS = 16'hff01;
  localparam logic [15:0] RAM_TAG_OFS = 16'hff0e;
  localparam logic [15:0] CFG_TAG_OFS = 16'hff19;
  localparam logic [15:0] CFG_SRC_OFS = 16'hff1a;
  localparam logic [15:0] CFG_CTL_OFS = 16'hff1b;
  localparam logic [15:0] SFR_LOW_OFS = 16'hfe20;
  localparam logic [15:0] SFR_MID_OFS = 16'hfe21;
  localparam logic [15:0] SFR_PIN_OFS = 16'hfe22;
  localparam logic [15:0] SFR_CTL_OFS = 16'hfe23;
  localparam logic [15:0] SFR_LATCH_OFS = 16'hfe24;

  // ------------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------------
  localparam int CTL_ON_BIT = 5;
  localparam int CFG_LARGE_BIT = 0;
  localparam int SIZE_FLOOR = 8;
  localparam logic [7:0] CTL_MASK = 8'h3f;
  localparam logic [7:0] CFG_SRC_MASK = 8'h0f;
  localparam logic [7:0] CFG_CTL_MASK = 8'h01;
  localparam logic [7:0] SFR_CTL_MASK = 8'h20;
  localparam logic [7:0] TAG_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CFG_SRC_RESET = 8'h0f;
  localparam logic [7:0] CFG_CTL_RESET = 8'h01;

  // ------------------------------------------------------------------
  // fixed physical layout
  // ------------------------------------------------------------------
  localparam logic [7:0] ROM_PAGE = 8'h00;
  localparam logic [7:0] RAM_PAGE = 8'h01;
  localparam logic [7:0] CFG_PAGE = 8'h02;
  localparam logic [3:0] CFG_TOP_NIBBLE = 4'hf;
  localparam int ROM_ADDR_BITS = 10;
  localparam int RAM_ALIAS_BITS = 13;
  localparam logic [2:0] RAM_ALIAS_BASE = 3'h4;

  // ------------------------------------------------------------------
  // processor access space encoding
  // ------------------------------------------------------------------
  localparam logic [1:0] SPACE_CODE = 2'h0;
  localparam logic [1:0] SPACE_DATA = 2'h1;
  localparam logic [1:0] SPACE_SFR = 2'h2;

endpackage

// ### rtl/addr_mapper.sv
// processor logical to system bus physical address mapper
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - ROM code mapper drives A31:24 from operand or opcode tag per fetch type
// - ROM code mapper is always on and catches every unclaimed code fetch
// - code mapper priority: two, then one, then ROM
// - code mappers one and two have own enables, off after reset
// - control register: enable bit 5, zone size bits 4:0, bits 7:6 unused
// - programmable code mapper tags A31:24 by operand or opcode fetch
// - low target byte gives A15:8, mid byte A23:16, unless passed through
// - zone source byte compared with logical A15:8 for zone match
// - data priority: config, five, four, two, one, then RAM
// - RAM mapper always on, drives A31:24 from its tag byte
// - data mappers one, two, four, five have own enables, off after reset
// - RAM low 32K at 0000h-7FFFh, top 8K aliased four times above
// - config mapper resets to 4K zone F000h-FFFFh, also offers 256 bytes
// - config zone on 4K boundary, source holds A15:12 in bits 3:0
// - config control bit 0 selects 4K when set, 256 when clear; reset set
// - config mapper always on; its 4K zone reaches every mapper register, the 256-byte zone misses the SFR export registers at FE20h-FE24h
// - enabled SPECIAL_FUNCTION_REGISTER export mapper puts full 32-bit address on the bus
// - SPECIAL_FUNCTION_REGISTER export mapper is disabled after reset
// - SPECIAL_FUNCTION_REGISTER access tags A31:24 from latch or pin tag per instruction type
// - exported SPECIAL_FUNCTION_REGISTER accesses are routed to the system bus
// - zone size is log2 bytes, 8 to 16, mask is two power minus one
// - mapper translates only when on and unmasked bits match source
// - masked low bits and A7:0 from logical, rest from target value
// - a miss falls to the next lower mapper; lowest always matches
module addr_mapper
  import mapper_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cpu_req,
  input wire logic [1:0] cpu_space,
  input wire logic cpu_opcode,
  input wire logic cpu_sfr_latch,
  input wire logic cpu_write,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  output logic bus_req,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [7:0] bus_wdata
);

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  logic [7:0] low_q [NPROG];
  logic [7:0] mid_q [NPROG];
  logic [7:0] high_q [NPROG];
  logic [7:0] src_q [NPROG];
  logic [7:0] ctl_q [NPROG];
  logic [7:0] alt_q [NCODE];
  logic [7:0] rom_operand_q, rom_opcode_q, ram_tag_q;
  logic [7:0] cfg_tag_q, cfg_src_q, cfg_ctl_q;
  logic [7:0] sfr_low_q, sfr_mid_q, sfr_pin_q, sfr_latch_q, sfr_ctl_q;
  logic [7:0] rdata_q;
  logic rvalid_q, bus_req_q, bus_write_q;
  logic [31:0] bus_addr_q;
  logic [7:0] bus_wdata_q;
  logic settled_q;

  // ------------------------------------------------------------------
  // zone mask: bit b of A15:8 passes through when size exceeds b+8
  // ------------------------------------------------------------------
  function automatic logic [7:0] pass_mask(input logic [4:0] size);
    logic [7:0] m;
    m = 8'h00;
    for (int b = 0; b < 8; b++) begin
      m[b] = (int'(size) > b + SIZE_FLOOR);
    end
    return m;
  endfunction

  // ------------------------------------------------------------------
  // access classification
  // ------------------------------------------------------------------
  wire logic is_code = cpu_req && (cpu_space == SPACE_CODE);
  wire logic is_data = cpu_req && (cpu_space == SPACE_DATA);
  wire logic is_sfr = cpu_req && (cpu_space == SPACE_SFR);
  wire logic sfr_on = sfr_ctl_q[CTL_ON_BIT];
  wire logic cfg_large = cfg_ctl_q[CFG_LARGE_BIT];

  // ------------------------------------------------------------------
  // programmable mapper match and translation
  // ------------------------------------------------------------------
  logic [NPROG-1:0] slot_hit;
  logic [31:0] slot_addr [NPROG];
  logic [NPROG-1:0] wr_low, wr_mid, wr_high, wr_src, wr_ctl;
  logic [NPROG-1:0] at_low, at_mid, at_high, at_src, at_ctl;
  logic [NCODE-1:0] wr_alt, at_alt;
  wire logic reg_access;
  wire logic [15:0] reg_ofs;

  for (genvar g = 0; g < NPROG; g++) begin : g_slot
    wire logic [7:0] pm = pass_mask(ctl_q[g][4:0]);
    wire logic [7:0] tag;
    wire logic [7:0] page = (low_q[g] & ~pm) | (cpu_addr[15:8] & pm);
    if (g < NCODE) begin : g_code
      assign tag = cpu_opcode ? alt_q[g] : high_q[g];
    end else begin : g_data
      assign tag = high_q[g];
    end
    assign slot_hit[g] = ctl_q[g][CTL_ON_BIT] &&
                         (((cpu_addr[15:8] ^ src_q[g]) & ~pm) == 8'h00);
    assign slot_addr[g] = {tag, mid_q[g], page, cpu_addr[7:0]};
    assign at_low[g] = (reg_ofs == LOW_OFS[g]);
    assign at_mid[g] = (reg_ofs == MID_OFS[g]);
    assign at_high[g] = (reg_ofs == HIGH_OFS[g]);
    assign at_src[g] = (reg_ofs == SRC_OFS[g]);
    assign at_ctl[g] = (reg_ofs == CTL_OFS[g]);
    assign wr_low[g] = reg_access && cpu_write && at_low[g];
    assign wr_mid[g] = reg_access && cpu_write && at_mid[g];
    assign wr_high[g] = reg_access && cpu_write && at_high[g];
    assign wr_src[g] = reg_access && cpu_write && at_src[g];
    assign wr_ctl[g] = reg_access && cpu_write && at_ctl[g];

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        low_q[g] <= TAG_RESET;
        mid_q[g] <= TAG_RESET;
        high_q[g] <= TAG_RESET;
        src_q[g] <= TAG_RESET;
        ctl_q[g] <= CTL_RESET;
      end else begin
        if (wr_low[g]) low_q[g] <= cpu_wdata;
        if (wr_mid[g]) mid_q[g] <= cpu_wdata;
        if (wr_high[g]) high_q[g] <= cpu_wdata;
        if (wr_src[g]) src_q[g] <= cpu_wdata;
        if (wr_ctl[g]) ctl_q[g] <= cpu_wdata & CTL_MASK;
      end
    end
  end

  for (genvar c = 0; c < NCODE; c++) begin : g_alt
    assign at_alt[c] = (reg_ofs == ALT_OFS[c]);
    assign wr_alt[c] = reg_access && cpu_write && at_alt[c];
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        alt_q[c] <= TAG_RESET;
      end else if (wr_alt[c]) begin
        alt_q[c] <= cpu_wdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // fixed mappers
  // ------------------------------------------------------------------
  wire logic [7:0] rom_tag = cpu_opcode ? rom_opcode_q : rom_operand_q;
  wire logic [31:0] rom_addr = {rom_tag, ROM_PAGE,
                                16'(cpu_addr[ROM_ADDR_BITS-1:0])};
  // low 32K direct, upper half folds the top 8K four times
  wire logic [15:0] ram_ofs = cpu_addr[15] ?
                              {RAM_ALIAS_BASE, cpu_addr[RAM_ALIAS_BITS-1:0]} :
                              cpu_addr;
  wire logic [31:0] ram_addr = {ram_tag_q, RAM_PAGE, ram_ofs};
  // config zone: 4K block chosen by source nibble, or its top 256 bytes
  wire logic cfg_hit = (cpu_addr[15:12] == cfg_src_q[3:0]) &&
                       (cfg_large || (cpu_addr[11:8] == CFG_TOP_NIBBLE));
  wire logic [31:0] cfg_addr = {cfg_tag_q, CFG_PAGE, CFG_TOP_NIBBLE, cpu_addr[11:0]};
  wire logic sfr_tag_sel = cpu_sfr_latch;
  wire logic [31:0] sfr_addr = {(sfr_tag_sel ? sfr_latch_q : sfr_pin_q),
                                sfr_mid_q, sfr_low_q, cpu_addr[7:0]};

  // ------------------------------------------------------------------
  // priority selection
  // ------------------------------------------------------------------
  wire logic [31:0] code_addr = slot_hit[SLOT_CODE_TWO] ? slot_addr[SLOT_CODE_TWO] :
                                slot_hit[SLOT_CODE_ONE] ? slot_addr[SLOT_CODE_ONE] :
                                rom_addr;
  wire logic [31:0] data_addr = cfg_hit ? cfg_addr :
                                slot_hit[SLOT_DATA_FIVE] ? slot_addr[SLOT_DATA_FIVE] :
                                slot_hit[SLOT_DATA_FOUR] ? slot_addr[SLOT_DATA_FOUR] :
                                slot_hit[SLOT_DATA_TWO] ? slot_addr[SLOT_DATA_TWO] :
                                slot_hit[SLOT_DATA_ONE] ? slot_addr[SLOT_DATA_ONE] :
                                ram_addr;
  wire logic [31:0] phys_addr = is_code ? code_addr : is_sfr ? sfr_addr : data_addr;

  // ------------------------------------------------------------------
  // mapper register decode, reached through the config zone
  // ------------------------------------------------------------------
  assign reg_ofs = cfg_addr[15:0];
  wire logic at_fixed = (reg_ofs == ROM_OPERAND_OFS) || (reg_ofs == ROM_OPCODE_OFS) ||
                        (reg_ofs == RAM_TAG_OFS) || (reg_ofs == CFG_TAG_OFS) ||
                        (reg_ofs == CFG_SRC_OFS) || (reg_ofs == CFG_CTL_OFS) ||
                        (reg_ofs == SFR_LOW_OFS) || (reg_ofs == SFR_MID_OFS) ||
                        (reg_ofs == SFR_PIN_OFS) || (reg_ofs == SFR_CTL_OFS) ||
                        (reg_ofs == SFR_LATCH_OFS);
  wire logic at_slot = |{at_low, at_mid, at_high, at_src, at_ctl, at_alt};
  assign reg_access = is_data && cfg_hit && (at_fixed || at_slot);
  wire logic wr_fixed = reg_access && cpu_write;
  // exported SFRs go out only while the export mapper is on
  wire logic to_bus = cpu_req && !reg_access && !(is_sfr && !sfr_on);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_operand_q <= TAG_RESET;
      rom_opcode_q <= TAG_RESET;
      ram_tag_q <= TAG_RESET;
      cfg_tag_q <= TAG_RESET;
      cfg_src_q <= CFG_SRC_RESET;
      cfg_ctl_q <= CFG_CTL_RESET;
      sfr_low_q <= TAG_RESET;
      sfr_mid_q <= TAG_RESET;
      sfr_pin_q <= TAG_RESET;
      sfr_latch_q <= TAG_RESET;
      sfr_ctl_q <= CTL_RESET;
    end else if (wr_fixed) begin
      if (reg_ofs == ROM_OPERAND_OFS) rom_operand_q <= cpu_wdata;
      if (reg_ofs == ROM_OPCODE_OFS) rom_opcode_q <= cpu_wdata;
      if (reg_ofs == RAM_TAG_OFS) ram_tag_q <= cpu_wdata;
      if (reg_ofs == CFG_TAG_OFS) cfg_tag_q <= cpu_wdata;
      if (reg_ofs == CFG_SRC_OFS) cfg_src_q <= cpu_wdata & CFG_SRC_MASK;
      if (reg_ofs == CFG_CTL_OFS) cfg_ctl_q <= cpu_wdata & CFG_CTL_MASK;
      if (reg_ofs == SFR_LOW_OFS) sfr_low_q <= cpu_wdata;
      if (reg_ofs == SFR_MID_OFS) sfr_mid_q <= cpu_wdata;
      if (reg_ofs == SFR_PIN_OFS) sfr_pin_q <= cpu_wdata;
      if (reg_ofs == SFR_CTL_OFS) sfr_ctl_q <= cpu_wdata & SFR_CTL_MASK;
      if (reg_ofs == SFR_LATCH_OFS) sfr_latch_q <= cpu_wdata;
    end
  end

  // ------------------------------------------------------------------
  // read-back mux
  // ------------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NPROG; i++) begin
      if (at_low[i]) rd_mux = low_q[i];
      if (at_mid[i]) rd_mux = mid_q[i];
      if (at_high[i]) rd_mux = high_q[i];
      if (at_src[i]) rd_mux = src_q[i];
      if (at_ctl[i]) rd_mux = ctl_q[i];
    end
    for (int i = 0; i < NCODE; i++) begin
      if (at_alt[i]) rd_mux = alt_q[i];
    end
    case (reg_ofs)
      ROM_OPERAND_OFS: rd_mux = rom_operand_q;
      ROM_OPCODE_OFS: rd_mux = rom_opcode_q;
      RAM_TAG_OFS: rd_mux = ram_tag_q;
      CFG_TAG_OFS: rd_mux = cfg_tag_q;
      CFG_SRC_OFS: rd_mux = cfg_src_q;
      CFG_CTL_OFS: rd_mux = cfg_ctl_q;
      SFR_LOW_OFS: rd_mux = sfr_low_q;
      SFR_MID_OFS: rd_mux = sfr_mid_q;
      SFR_PIN_OFS: rd_mux = sfr_pin_q;
      SFR_CTL_OFS: rd_mux = sfr_ctl_q;
      SFR_LATCH_OFS: rd_mux = sfr_latch_q;
      default: rd_mux = rd_mux;
    endcase
  end

  // ------------------------------------------------------------------
  // answer registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_access && !cpu_write;
      if (reg_access && !cpu_write) rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_req_q <= 1'b0;
      bus_write_q <= 1'b0;
      bus_addr_q <= 32'h0000_0000;
      bus_wdata_q <= 8'h00;
    end else begin
      bus_req_q <= to_bus;
      if (to_bus) begin
        bus_write_q <= cpu_write;
        bus_addr_q <= phys_addr;
        bus_wdata_q <= cpu_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settled_q <= 1'b0;
    end else begin
      settled_q <= 1'b1;
    end
  end

  assign cpu_rdata = rdata_q;
  assign cpu_rvalid = rvalid_q;
  assign bus_req = bus_req_q;
  assign bus_write = bus_write_q;
  assign bus_addr = bus_addr_q;
  assign bus_wdata = bus_wdata_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_ROM_TAG: assert property (@(posedge clk) disable iff (!arst_n)
    (is_code && !slot_hit[SLOT_CODE_TWO] && !slot_hit[SLOT_CODE_ONE])
    |=> bus_req && bus_addr[31:24] == ($past(cpu_opcode) ? $past(rom_opcode_q) :
                                       $past(rom_operand_q)))
    else $error("rom code tag wrong");

  AST_CODE_PRIO: assert property (@(posedge clk) disable iff (!arst_n)
    (is_code && slot_hit[SLOT_CODE_TWO] && cpu_opcode)
    |=> bus_addr[31:24] == $past(alt_q[SLOT_CODE_TWO]))
    else $error("code mapper two not preferred");

  AST_RESET_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    !settled_q |-> !ctl_q[SLOT_CODE_ONE][CTL_ON_BIT] && !ctl_q[SLOT_DATA_FIVE][CTL_ON_BIT]
                   && !sfr_on)
    else $error("mapper enabled after reset");

  AST_CFG_RESET: assert property (@(posedge clk) disable iff (!arst_n)
    !settled_q |-> cfg_large && cfg_src_q == CFG_SRC_RESET)
    else $error("config zone reset wrong");

  AST_CFG_FIRST: assert property (@(posedge clk) disable iff (!arst_n)
    (is_data && cfg_hit && !reg_access) |=> bus_addr[23:16] == CFG_PAGE)
    else $error("config mapper not first");

  AST_RAM_ALIAS: assert property (@(posedge clk) disable iff (!arst_n)
    (is_data && !cfg_hit && slot_hit[NPROG-1:SLOT_DATA_ONE] == 4'h0 && cpu_addr[15])
    |=> bus_addr[15:13] == RAM_ALIAS_BASE && bus_addr[23:16] == RAM_PAGE)
    else $error("ram alias wrong");

  AST_SFR_GATE: assert property (@(posedge clk) disable iff (!arst_n)
    (is_sfr && !sfr_on) |=> !bus_req)
    else $error("sfr access leaked while off");

  AST_SFR_TAG: assert property (@(posedge clk) disable iff (!arst_n)
    (is_sfr && sfr_on && cpu_sfr_latch) |=> bus_req && bus_addr[31:24] == $past(sfr_latch_q))
    else $error("sfr latch tag wrong");

  AST_LOW_BYTE: assert property (@(posedge clk) disable iff (!arst_n)
    (cpu_req && !reg_access && !is_sfr) |=> bus_addr[7:0] == $past(cpu_addr[7:0]))
    else $error("low byte not passed");

  AST_REG_LOCAL: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_access && !cpu_write) |=> cpu_rvalid && !bus_req)
    else $error("register access escaped");

  AST_READBACK: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_fixed && reg_ofs == RAM_TAG_OFS) ##1 (reg_access && !cpu_write && reg_ofs == RAM_TAG_OFS)
    |=> cpu_rdata == $past(cpu_wdata, 2))
    else $error("read-back mismatch");

endmodule

`default_nettype wire

// ### tb/bus_slave_model.sv
// system bus slave model that keeps the last forwarded write
`timescale 1ns/10ps
`default_nettype none
module bus_slave_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [31:0] last_addr,
  output logic [7:0] last_wdata
);
  // ------------------------------------------------------------------
  // write capture
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_addr <= 32'h0000_0000;
      last_wdata <= 8'h00;
    end else if (bus_req && bus_write) begin
      last_addr <= bus_addr;
      last_wdata <= bus_wdata;
    end
  end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the address mapper
`timescale 1ns/10ps
`default_nettype none
module testbench
  import mapper_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cpu_req = 1'b0;
  logic [1:0] cpu_space = 2'h0;
  logic cpu_opcode = 1'b0;
  logic cpu_sfr_latch = 1'b0;
  logic cpu_write = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00;
  wire logic [7:0] cpu_rdata;
  wire logic cpu_rvalid;
  wire logic bus_req;
  wire logic bus_write;
  wire logic [31:0] bus_addr;
  wire logic [7:0] bus_wdata;
  wire logic [31:0] last_addr;
  wire logic [7:0] last_wdata;
  int error_cnt = 0;
  int checked = 0;
  int s;
  always #2 clk = ~clk;
  addr_mapper u_addr_mapper (.clk(clk), .arst_n(arst_n), .cpu_req(cpu_req),
    .cpu_space(cpu_space), .cpu_opcode(cpu_opcode), .cpu_sfr_latch(cpu_sfr_latch),
    .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .bus_req(bus_req),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata));
  bus_slave_model u_bus_slave_model (.clk(clk), .arst_n(arst_n), .bus_req(bus_req),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .last_addr(last_addr), .last_wdata(last_wdata));
  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic req(input logic [1:0] sp, input logic op, input logic la,
    input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_space <= sp;
    cpu_opcode <= op;
    cpu_sfr_latch <= la;
    cpu_write <= wr;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_req <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    req(SPACE_DATA, 1'b0, 1'b0, 1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    req(SPACE_DATA, 1'b0, 1'b0, 1'b0, a, 8'h00);
    chk({31'h0, cpu_rvalid}, 32'h0000_0001);
    chk({24'h0, cpu_rdata}, {24'h0, e});
  endtask
  task automatic go(input logic [1:0] sp, input logic op, input logic la,
    input logic [15:0] a, input logic [31:0] e);
    req(sp, op, la, 1'b0, a, 8'h00);
    chk({31'h0, bus_req}, 32'h0000_0001);
    chk(bus_addr, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    report_and_stop;
  end
  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rd(CFG_SRC_OFS, 8'h0f);
    rd(CFG_CTL_OFS, 8'h01);
    rd(CTL_OFS[SLOT_CODE_ONE], 8'h00);
    rd(CTL_OFS[SLOT_DATA_FIVE], 8'h00);
    rd(SFR_CTL_OFS, 8'h00);
    $display("test reset values done");
    wr(ROM_OPERAND_OFS, 8'h20);
    wr(ROM_OPCODE_OFS, 8'h40);
    go(SPACE_CODE, 1'b0, 1'b0, 16'h1234, 32'h2000_0234);
    go(SPACE_CODE, 1'b1, 1'b0, 16'h1234, 32'h4000_0234);
    rd(ROM_OPCODE_OFS, 8'h40);
    wr(LOW_OFS[SLOT_CODE_ONE], 8'h12);
    wr(MID_OFS[SLOT_CODE_ONE], 8'h34);
    wr(HIGH_OFS[SLOT_CODE_ONE], 8'h28);
    wr(ALT_OFS[SLOT_CODE_ONE], 8'h48);
    wr(SRC_OFS[SLOT_CODE_ONE], 8'h40);
    wr(CTL_OFS[SLOT_CODE_ONE], 8'h29);
    go(SPACE_CODE, 1'b0, 1'b0, 16'h4155, 32'h2834_1355);
    go(SPACE_CODE, 1'b1, 1'b0, 16'h4155, 32'h4834_1355);
    go(SPACE_CODE, 1'b0, 1'b0, 16'h4355, 32'h2000_0355);
    wr(LOW_OFS[SLOT_CODE_TWO], 8'hab);
    wr(MID_OFS[SLOT_CODE_TWO], 8'hcd);
    wr(HIGH_OFS[SLOT_CODE_TWO], 8'h30);
    wr(ALT_OFS[SLOT_CODE_TWO], 8'h50);
    wr(SRC_OFS[SLOT_CODE_TWO], 8'h40);
    wr(CTL_OFS[SLOT_CODE_TWO], 8'h28);
    go(SPACE_CODE, 1'b0, 1'b0, 16'h4055, 32'h30cd_ab55);
    go(SPACE_CODE, 1'b1, 1'b0, 16'h4055, 32'h50cd_ab55);
    go(SPACE_CODE, 1'b0, 1'b0, 16'h4155, 32'h2834_1355);
    wr(CTL_OFS[SLOT_CODE_TWO], 8'h08);
    go(SPACE_CODE, 1'b0, 1'b0, 16'h4055, 32'h2834_1255);
    $display("test code mappers done");
    // back-to-back write then read of the ram tag
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_space <= SPACE_DATA;
    cpu_write <= 1'b1;
    cpu_addr <= RAM_TAG_OFS;
    cpu_wdata <= 8'h80;
    @(posedge clk);
    cpu_write <= 1'b0;
    @(posedge clk);
    cpu_req <= 1'b0;
    #1;
    chk({31'h0, cpu_rvalid}, 32'h0000_0001);
    chk({24'h0, cpu_rdata}, 32'h0000_0080);
    go(SPACE_DATA, 1'b0, 1'b0, 16'h1234, 32'h8001_1234);
    go(SPACE_DATA, 1'b0, 1'b0, 16'he765, 32'h8001_8765);
    go(SPACE_DATA, 1'b0, 1'b0, 16'ha765, 32'h8001_8765);
    req(SPACE_DATA, 1'b0, 1'b0, 1'b1, 16'h1234, 8'hc3);
    chk({31'h0, bus_write}, 32'h0000_0001);
    @(posedge clk);
    #1;
    chk({24'h0, last_wdata}, 32'h0000_00c3);
    chk(last_addr, 32'h8001_1234);
    for (s = SLOT_DATA_ONE; s <= SLOT_DATA_FIVE; s++) begin
      wr(LOW_OFS[s], 8'h20 + 8'(s));
      wr(MID_OFS[s], 8'h10 + 8'(s));
      wr(HIGH_OFS[s], 8'h80 + 8'(s));
      wr(SRC_OFS[s], 8'h80);
      wr(CTL_OFS[s], 8'h28);
      go(SPACE_DATA, 1'b0, 1'b0, 16'h8012,
        {8'h80 + 8'(s), 8'h10 + 8'(s), 8'h20 + 8'(s), 8'h12});
    end
    wr(CTL_OFS[SLOT_DATA_ONE], 8'hff);
    rd(CTL_OFS[SLOT_DATA_ONE], 8'h3f);
    wr(CFG_SRC_OFS, 8'hff);
    rd(CFG_SRC_OFS, 8'h0f);
    wr(CFG_TAG_OFS, 8'h98);
    wr(CFG_SRC_OFS, 8'h0e);
    go(SPACE_DATA, 1'b0, 1'b0, 16'he765, 32'h9802_f765);
    rd(16'hef1a, 8'h0e);
    wr(16'hef1a, 8'h0f);
    wr(SRC_OFS[SLOT_DATA_FIVE], 8'hf0);
    go(SPACE_DATA, 1'b0, 1'b0, 16'hf012, 32'h9802_f012);
    wr(CFG_CTL_OFS, 8'h00);
    go(SPACE_DATA, 1'b0, 1'b0, 16'hf012, 32'h8515_2512);
    go(SPACE_DATA, 1'b0, 1'b0, 16'hff30, 32'h9802_ff30);
    rd(CFG_CTL_OFS, 8'h00);
    wr(CFG_CTL_OFS, 8'h01);
    $display("test data mappers done");
    req(SPACE_SFR, 1'b0, 1'b1, 1'b0, 16'h0090, 8'h00);
    chk({31'h0, bus_req}, 32'h0000_0000);
    wr(SFR_LOW_OFS, 8'h5a);
    wr(SFR_MID_OFS, 8'h6b);
    wr(SFR_PIN_OFS, 8'hc0);
    wr(SFR_LATCH_OFS, 8'he0);
    wr(SFR_CTL_OFS, 8'h20);
    go(SPACE_SFR, 1'b0, 1'b1, 16'h0090, 32'he06b_5a90);
    go(SPACE_SFR, 1'b0, 1'b0, 16'h0090, 32'hc06b_5a90);
    $display("test sfr export done");
    report_and_stop;
  end
endmodule
`default_nettype wire
